// [mrb_consts.vh]
/*
 * Address map constants for the region decoder and bit-band remapper.
 * Assumes a 32-bit byte address and little-endian byte lanes.
 */
`ifndef MRB_CONSTS_VH
`define MRB_CONSTS_VH

`define MRB_CODE_BASE 32'h00000000
`define MRB_SRAM_BASE 32'h20000000
`define MRB_SRAM_TOP 32'h3fffffff
`define MRB_PERI_BASE 32'h40000000
`define MRB_XRAM_BASE 32'h60000000
`define MRB_XDEV_BASE 32'ha0000000
`define MRB_XDEV_TOP 32'hdfffffff
`define MRB_PPB_BASE 32'he0000000
`define MRB_PPB_TOP 32'he00fffff
`define MRB_SRAM_BB_BASE 32'h20000000
`define MRB_SRAM_BB_TOP 32'h200fffff
`define MRB_SRAM_AL_BASE 32'h22000000
`define MRB_SRAM_AL_TOP 32'h23ffffff
`define MRB_PERI_BB_BASE 32'h40000000
`define MRB_PERI_BB_TOP 32'h400fffff
`define MRB_PERI_AL_BASE 32'h42000000
`define MRB_PERI_AL_TOP 32'h43ffffff
`define MRB_BB_SPAN_BITS 20
`define MRB_AL_SPAN_BITS 25

`define MRB_TYPE_NORMAL 2'h0
`define MRB_TYPE_DEVICE 2'h1
`define MRB_TYPE_SORD 2'h2
`define MRB_TYPE_NONE 2'h3

`define MRB_SIZE_BYTE 2'h0
`define MRB_SIZE_HALF 2'h1
`define MRB_SIZE_WORD 2'h2

`define MRB_BAR_NONE 2'h0
`define MRB_BAR_DMB 2'h1
`define MRB_BAR_DSB 2'h2
`define MRB_BAR_ISB 2'h3

`endif

// [mrb_region_decode.v]
/*
 * Combinational default address map: region type, no-execute and error class.
 * Assumes a protection unit override is applied by the caller.
 */
module mrb_region_decode (
  input wire [31:0] addr,
  output reg [1:0] mem_type,
  output reg no_execute_attribute,
  output reg unmapped
);
`include "mrb_consts.vh"

  always @* begin
    mem_type = `MRB_TYPE_NONE;
    no_execute_attribute = 1'b1;
    unmapped = 1'b0;
    if (addr < `MRB_SRAM_BASE) begin
      mem_type = `MRB_TYPE_NORMAL;
      no_execute_attribute = 1'b0;
    end else if (addr <= `MRB_SRAM_TOP) begin
      mem_type = `MRB_TYPE_NORMAL;
      no_execute_attribute = 1'b0;
    end else if (addr < `MRB_XRAM_BASE) begin
      mem_type = `MRB_TYPE_DEVICE;
    end else if (addr < `MRB_XDEV_BASE) begin
      mem_type = `MRB_TYPE_NORMAL;
      no_execute_attribute = 1'b0;
    end else if (addr <= `MRB_XDEV_TOP) begin
      mem_type = `MRB_TYPE_DEVICE;
    end else if (addr <= `MRB_PPB_TOP) begin
      mem_type = `MRB_TYPE_SORD;
    end else begin
      unmapped = 1'b1;
    end
  end
endmodule

// [mrb_bitband_bridge.v]
/*
 * Bit-band bridge: classifies each processor access, remaps alias data accesses
 * to single-bit reads or read-modify-writes on the bit-band area, buffers one Device
 * write, and sequences the three barrier kinds.
 * Assumes one master request at a time held until acknowledged, and a slave
 * that answers each request with a one-cycle ack and optional error.
 */
`include "mrb_consts.vh"

module mrb_bitband_bridge (
  input wire clock,
  input wire reset,
  // Master side
  input wire m_req,
  input wire m_write,
  input wire m_fetch,
  input wire [1:0] m_size,
  input wire [31:0] m_addr,
  input wire [31:0] m_wdata,
  input wire [1:0] m_barrier,
  input wire prio_change,
  output reg m_ack,
  output reg m_err,
  output reg m_xn_fault,
  output reg [31:0] m_rdata,
  output reg [1:0] m_type,
  output reg m_xn,
  output reg prio_commit,
  output reg flush_fetch,
  // Protection unit override
  input wire pu_enable,
  input wire pu_hit,
  input wire [1:0] pu_type,
  input wire pu_xn,
  // Slave side
  output reg s_req,
  output reg s_write,
  output reg [1:0] s_size,
  output reg [31:0] s_addr,
  output reg [31:0] s_wdata,
  output reg s_lock,
  input wire s_ack,
  input wire s_err,
  input wire [31:0] s_rdata
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ACC = 7'h02;
  localparam [6:0] ST_RMW_RD = 7'h04;
  localparam [6:0] ST_RMW_WR = 7'h08;
  localparam [6:0] ST_DRAIN = 7'h10;
  localparam [6:0] ST_DONE = 7'h20;
  localparam [6:0] ST_BUFWR = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg wbuf_full;
  reg wbuf_busy;
  reg [1:0] bar_kind;
  reg prio_pending;
  reg [2:0] alias_bit;
  reg [31:0] hold_wdata;
  reg hold_write;

  wire [1:0] map_type;
  wire map_xn;
  wire map_unmapped;

  mrb_region_decode u_dec (
    .addr(m_addr),
    .mem_type(map_type),
    .no_execute_attribute(map_xn),
    .unmapped(map_unmapped)
  );

  // Alias word to bit-band byte address: drop bit number and word lane
  function [31:0] alias_target;
    input [31:0] a;
    input [31:0] bb_base;
    begin
      alias_target = bb_base | {12'h000, a[24:5]};
    end
  endfunction

  function in_range;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // Reserved holes inside the SRAM and peripheral regions are not decoded
  // here; the slave answers those with its own error.
  wire hit_sram_al = in_range(m_addr, `MRB_SRAM_AL_BASE, `MRB_SRAM_AL_TOP);
  wire hit_peri_al = in_range(m_addr, `MRB_PERI_AL_BASE, `MRB_PERI_AL_TOP);
  wire eff_override = pu_enable && pu_hit;
  wire [1:0] eff_type = eff_override ? pu_type : map_type;
  wire eff_xn = eff_override ? pu_xn : map_xn;
  wire do_alias = !m_fetch && (hit_sram_al || hit_peri_al);
  wire fetch_refused = m_fetch && (eff_xn || hit_peri_al);
  wire [31:0] alias_addr = hit_sram_al ? alias_target(m_addr, `MRB_SRAM_BB_BASE)
                                       : alias_target(m_addr, `MRB_PERI_BB_BASE);
  // Device writes other than alias writes are posted; Strongly Ordered and Normal go straight through
  wire can_post = m_write && !m_fetch && !do_alias && eff_type == `MRB_TYPE_DEVICE &&
                  !map_unmapped;
  // Hold off a new request in the cycle the posted write is acknowledged,
  // otherwise that ack is lost and the Device write goes out twice
  wire start = m_req && state == ST_IDLE && !m_ack && !(wbuf_busy && s_ack);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          if (m_barrier != `MRB_BAR_NONE) begin
            next_state = wbuf_full ? ST_DRAIN : ST_DONE;
          end else if (map_unmapped || fetch_refused) begin
            next_state = ST_DONE;
          end else if (wbuf_full) begin
            next_state = ST_DRAIN;
          end else if (can_post) begin
            next_state = ST_BUFWR;
          end else if (do_alias) begin
            next_state = ST_RMW_RD;
          end else begin
            next_state = ST_ACC;
          end
        end
      end
      ST_ACC: if (s_ack) next_state = ST_DONE;
      ST_RMW_RD: begin
        if (s_ack) next_state = (hold_write && !s_err) ? ST_RMW_WR : ST_DONE;
      end
      ST_RMW_WR: if (s_ack) next_state = ST_DONE;
      ST_DRAIN: if (s_ack) next_state = ST_IDLE;
      ST_BUFWR: next_state = ST_IDLE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      wbuf_full <= 1'b0;
      wbuf_busy <= 1'b0;
      bar_kind <= `MRB_BAR_NONE;
      prio_pending <= 1'b0;
      alias_bit <= 3'h0;
      hold_wdata <= 32'h00000000;
      hold_write <= 1'b0;
      m_ack <= 1'b0;
      m_err <= 1'b0;
      m_xn_fault <= 1'b0;
      m_rdata <= 32'h00000000;
      m_type <= `MRB_TYPE_NONE;
      m_xn <= 1'b1;
      prio_commit <= 1'b0;
      flush_fetch <= 1'b0;
      s_req <= 1'b0;
      s_write <= 1'b0;
      s_size <= `MRB_SIZE_WORD;
      s_addr <= 32'h00000000;
      s_wdata <= 32'h00000000;
      s_lock <= 1'b0;
    end else begin
      state <= next_state;
      m_ack <= 1'b0;
      prio_commit <= 1'b0;
      flush_fetch <= 1'b0;
      if (prio_change) begin
        prio_pending <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (start) begin
            m_err <= 1'b0;
            m_xn_fault <= 1'b0;
            m_rdata <= 32'h00000000;
            m_type <= eff_type;
            m_xn <= eff_xn;
            bar_kind <= m_barrier;
            alias_bit <= m_addr[4:2];
            hold_wdata <= m_wdata;
            hold_write <= m_write;
            if (m_barrier != `MRB_BAR_NONE) begin
              if (wbuf_full) begin
                s_req <= 1'b1;
              end
            end else if (map_unmapped || fetch_refused) begin
              m_err <= 1'b1;
              // The fault is only a flag; the core raises it if it executes
              m_xn_fault <= fetch_refused;
            end else if (wbuf_full) begin
              s_req <= 1'b1;
            end else if (can_post) begin
              wbuf_full <= 1'b1;
              s_write <= 1'b1;
              s_size <= m_size;
              s_addr <= m_addr;
              s_wdata <= m_wdata;
            end else if (do_alias) begin
              s_req <= 1'b1;
              s_lock <= 1'b1;
              s_write <= 1'b0;
              s_size <= `MRB_SIZE_BYTE;
              s_addr <= alias_addr;
            end else begin
              s_req <= 1'b1;
              s_write <= m_write;
              s_size <= m_size;
              s_addr <= m_addr;
              s_wdata <= m_wdata;
            end
          end else if (wbuf_full && !wbuf_busy) begin
            // Idle bus: let the posted write go out on its own
            s_req <= 1'b1;
            wbuf_busy <= 1'b1;
          end else if (wbuf_busy && s_ack) begin
            s_req <= 1'b0;
            wbuf_busy <= 1'b0;
            wbuf_full <= 1'b0;
          end
        end
        ST_ACC: begin
          if (s_ack) begin
            s_req <= 1'b0;
            m_err <= s_err;
            m_rdata <= s_rdata;
          end
        end
        ST_RMW_RD: begin
          if (s_ack) begin
            if (hold_write && !s_err) begin
              s_write <= 1'b1;
              // Modify the byte from its own lane so neighbouring bits survive
              s_wdata <= {4{(s_rdata[{s_addr[1:0], 3'h0} +: 8] & ~(8'h01 << alias_bit)) |
                            ({7'h00, hold_wdata[0]} << alias_bit)}};
            end else begin
              s_req <= 1'b0;
              s_lock <= 1'b0;
              m_err <= s_err;
              m_rdata <= {31'h00000000, s_rdata[{s_addr[1:0], alias_bit}]};
            end
          end
        end
        ST_RMW_WR: begin
          if (s_ack) begin
            s_req <= 1'b0;
            s_lock <= 1'b0;
            s_write <= 1'b0;
            m_err <= s_err;
          end
        end
        ST_DRAIN: begin
          if (s_ack) begin
            s_req <= 1'b0;
            s_write <= 1'b0;
            wbuf_full <= 1'b0;
            wbuf_busy <= 1'b0;
          end
        end
        ST_BUFWR: m_ack <= 1'b1;
        ST_DONE: begin
          m_ack <= 1'b1;
          if (bar_kind == `MRB_BAR_DSB && (prio_pending || prio_change)) begin
            prio_commit <= 1'b1;
            prio_pending <= 1'b0;
          end
          if (bar_kind == `MRB_BAR_ISB) begin
            flush_fetch <= 1'b1;
          end
        end
        default: s_req <= 1'b0;
      endcase
    end
  end
endmodule

// [mrb_checker.sv]
/* Port assertions for the bit-band bridge.
   Assumes binding onto mrb_bitband_bridge with matching port names. */
`include "mrb_consts.vh"
module mrb_checker (
  input wire clock, reset, m_req, m_write, m_fetch, m_ack, m_err, m_xn_fault,
  input wire m_xn, prio_commit, flush_fetch, pu_enable,
  input wire s_req, s_write, s_lock, s_ack,
  input wire [1:0] m_barrier, m_type, s_size,
  input wire [31:0] m_addr, m_wdata, s_addr, s_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire acc = m_req && m_ack && m_barrier == `MRB_BAR_NONE;
  wire dat = acc && !pu_enable && !m_fetch;
  wire ppb = m_addr >= `MRB_PPB_BASE && m_addr <= `MRB_PPB_TOP;
  wire al = m_req && !m_fetch && m_barrier == `MRB_BAR_NONE &&
    (m_addr[31:25] == 7'h11 || m_addr[31:25] == 7'h21);
  AST_UNMAPPED: assert property (acc && m_addr >= 32'he0100000 |-> m_err)
    else $error("unmapped access not errored");
  AST_PERIPH: assert property (dat && m_addr[31:29] == 3'b010 |->
    m_type == `MRB_TYPE_DEVICE && m_xn) else $error("peripheral attributes");
  AST_PPB: assert property (dat && ppb |-> m_type == `MRB_TYPE_SORD && m_xn)
    else $error("private region attributes");
  AST_XN_FETCH: assert property (acc && !pu_enable && m_fetch &&
    m_addr >= `MRB_XDEV_BASE && m_addr <= `MRB_PPB_TOP |-> m_err && m_xn_fault)
    else $error("no-execute fetch passed");
  // Drains are plain writes, so only locked or read slave cycles belong to the alias
  AST_ALIAS_ADDR: assert property (al && s_req && (s_lock || !s_write) |->
    s_addr == {m_addr[31:26], 6'h0, m_addr[24:5]} && s_size == `MRB_SIZE_BYTE)
    else $error("alias remap address");
  AST_LOCK_RMW: assert property (al && m_write && s_ack && !s_write |->
    s_lock ##1 (s_req && s_write && s_lock)) else $error("alias rmw not locked");
  AST_ALIAS_BIT: assert property (al && m_write && s_req && s_write && s_lock |->
    s_wdata[{s_addr[1:0], m_addr[4:2]}] == m_wdata[0]) else $error("alias bit value");
  AST_SO_SYNC: assert property (acc && m_write && !m_err && ppb |->
    $past(s_ack, 2)) else $error("ordered write acked early");
  AST_BAR_DRAIN: assert property (m_req && m_ack && m_barrier != 2'h0 |-> !s_req)
    else $error("barrier with slave busy");
  AST_ISB_FLUSH: assert property (flush_fetch |->
    m_ack && m_barrier == `MRB_BAR_ISB) else $error("stray refetch");
  AST_DSB_COMMIT: assert property (prio_commit |->
    m_ack && m_barrier == `MRB_BAR_DSB) else $error("stray priority commit");
  cover property (al && m_write && s_ack && s_write);
  cover property (flush_fetch);
  cover property (prio_commit);
endmodule
bind mrb_bitband_bridge mrb_checker chk (.*);

// [mrb_slave_model.sv]
/* Memory slave: 16 words with byte lanes, answer delayed by lat cycles.
   Assumes a request held until acknowledged. */
module mrb_slave_model (
  input wire clock, reset, s_req, s_write,
  input wire [3:0] lat,
  input wire [1:0] s_size,
  input wire [31:0] s_addr, s_wdata,
  output reg s_ack, s_err,
  output reg [31:0] s_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] mem [0:15];
  reg [3:0] cnt;
  wire [3:0] idx = s_addr[5:2];
  integer i;
  initial for (i = 0; i < 16; i++) mem[i] = 32'h0;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      s_ack <= 1'b0;
      s_err <= 1'b0;
      s_rdata <= 32'h0;
    end else begin
      s_ack <= 1'b0;
      // Read data is only valid with the ack, so it keeps changing otherwise
      s_rdata <= ~s_rdata;
      if (s_req && !s_ack && cnt >= lat) begin
        cnt <= 4'h0;
        s_ack <= 1'b1;
        s_rdata <= mem[idx];
        for (i = 0; i < 4; i++)
          if (s_write && (s_size == 2'h2 || (s_size == 2'h1 && i[1] == s_addr[1])
              || i[1:0] == s_addr[1:0]))
            mem[idx][8*i+:8] <= s_wdata[8*i+:8];
      end else if (s_req && !s_ack) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// [mrb_bitband_bridge_bench.sv]
/* Self-checking bench for the bit-band bridge and its memory slave.
   Assumes the checker is bound to the design separately. */
`include "mrb_consts.vh"
module mrb_bitband_bridge_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, m_req, m_write, m_fetch, prio_change, pu_enable, pu_hit, pu_xn;
  logic m_ack, m_err, m_xn_fault, m_xn, prio_commit, flush_fetch;
  logic s_req, s_write, s_lock, s_ack, s_err, r_err, r_xf, r_xn, r_pc, r_ff;
  logic [1:0] m_size, m_barrier, m_type, pu_type, s_size, r_type;
  logic [31:0] m_addr, m_wdata, m_rdata, s_addr, s_wdata, s_rdata, last_saddr, r_data;
  logic [3:0] lat;
  int mismatches = 0;
  int checked = 0;
  mrb_bitband_bridge dut (.*);
  mrb_slave_model slv (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (s_req) last_saddr <= s_addr;
  task chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, f, input logic [1:0] sz, bar, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clock);
    {m_req, m_write, m_fetch, m_size, m_barrier} <= {1'b1, w, f, sz, bar};
    {m_addr, m_wdata} <= {a, d};
    do begin
      @(posedge clock);
      n++;
    end while (m_ack !== 1'b1 && n < 80);
    if (m_ack !== 1'b1) mismatches++;
    {r_err, r_xf, r_xn, r_pc, r_ff} = {m_err, m_xn_fault, m_xn, prio_commit, flush_fetch};
    {r_type, r_data} = {m_type, m_rdata};
    m_req <= 1'b0;
  endtask
  task rd(input logic [31:0] a);
    xfer(1'b0, 1'b0, `MRB_SIZE_WORD, `MRB_BAR_NONE, a, 32'h0);
  endtask
  task wr(input logic [31:0] a, d);
    xfer(1'b1, 1'b0, `MRB_SIZE_WORD, `MRB_BAR_NONE, a, d);
  endtask
  task row(input logic [31:0] a, input logic [1:0] ty, input logic xn);
    rd(a);
    chk(r_err, 1'b0);
    chk(r_type, ty);
    chk(r_xn, xn);
  endtask
  task frow(input logic [31:0] a, input logic er);
    xfer(1'b0, 1'b1, `MRB_SIZE_WORD, `MRB_BAR_NONE, a, 32'h0);
    chk(r_err, er);
    chk(r_xf, er);
  endtask
  task t_regions;
    row(32'h1ffffffc, `MRB_TYPE_NORMAL, 1'b0);
    row(32'h3ffffffc, `MRB_TYPE_NORMAL, 1'b0);
    row(32'h5ffffffc, `MRB_TYPE_DEVICE, 1'b1);
    row(32'h60000000, `MRB_TYPE_NORMAL, 1'b0);
    row(32'hdffffffc, `MRB_TYPE_DEVICE, 1'b1);
    row(32'he00ffffc, `MRB_TYPE_SORD, 1'b1);
    rd(32'he0100000);
    chk(r_err, 1'b1);
    $display("regions done");
  endtask
  task t_fetch;
    frow(32'h00000100, 1'b0);
    frow(32'h60000000, 1'b0);
    frow(32'ha0000000, 1'b1);
    frow(32'he0000000, 1'b1);
    frow(32'h42000004, 1'b1);
    frow(32'h22000004, 1'b0);
    chk(last_saddr, 32'h22000004);
    {pu_enable, pu_hit, pu_type, pu_xn} <= {2'b11, `MRB_TYPE_NORMAL, 1'b0};
    frow(32'h40000000, 1'b0);
    pu_hit <= 1'b0;
    frow(32'h40000000, 1'b1);
    pu_enable <= 1'b0;
    $display("fetch done");
  endtask
  task t_alias(input logic [31:0] bb, al);
    lat <= 4'h2;
    wr(bb, 32'h000000a5);
    wr(al + 32'h2c, 32'h1);
    rd(bb);
    chk(r_data, 32'h000008a5);
    rd(al + 32'h2c);
    chk(r_data, 32'h1);
    rd(al + 32'h28);
    chk(r_data, 32'h0);
    wr(al + 32'h2c, 32'h0e);
    rd(bb);
    chk(r_data, 32'h000000a5);
    wr(bb + 32'hffffc, 32'h0);
    wr(al + 32'h1fffffc, 32'hff);
    rd(bb + 32'hffffc);
    chk(r_data, 32'h80000000);
    lat <= 4'h0;
    $display("alias done");
  endtask
  task t_size;
    wr(32'h20000004, 32'h11223344);
    xfer(1'b1, 1'b0, `MRB_SIZE_HALF, `MRB_BAR_NONE, 32'h20000006, 32'hbeefbeef);
    xfer(1'b1, 1'b0, `MRB_SIZE_BYTE, `MRB_BAR_NONE, 32'h20000004, 32'h99999999);
    rd(32'h20000004);
    chk(r_data, 32'hbeef3399);
    // Posted peripheral byte write must land before the read that follows
    xfer(1'b1, 1'b0, `MRB_SIZE_BYTE, `MRB_BAR_NONE, 32'h40000005, 32'h77777777);
    rd(32'h40000004);
    chk(r_data, 32'hbeef7799);
    $display("size done");
  endtask
  task t_barrier;
    lat <= 4'h3;
    wr(32'ha0000008, 32'h5);
    xfer(1'b0, 1'b0, `MRB_SIZE_WORD, `MRB_BAR_DMB, 32'h0, 32'h0);
    chk(r_ff, 1'b0);
    wr(32'ha0000008, 32'h6);
    prio_change <= 1'b1;
    @(posedge clock);
    prio_change <= 1'b0;
    xfer(1'b0, 1'b0, `MRB_SIZE_WORD, `MRB_BAR_DSB, 32'h0, 32'h0);
    chk(r_pc, 1'b1);
    xfer(1'b0, 1'b0, `MRB_SIZE_WORD, `MRB_BAR_ISB, 32'h0, 32'h0);
    chk(r_ff, 1'b1);
    wr(32'he0000008, 32'h7);
    chk(r_type, `MRB_TYPE_SORD);
    $display("barrier done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {reset, m_req, m_write, m_fetch, prio_change, pu_enable, pu_hit, pu_xn} = 8'h80;
    {m_size, m_barrier, pu_type, lat, m_addr, m_wdata} = 74'h0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_regions;
    t_fetch;
    t_alias(32'h20000000, 32'h22000000);
    t_alias(32'h40000000, 32'h42000000);
    t_size;
    t_barrier;
    summarize;
  end
  // Some fifty transfers of under twenty cycles each; far more than enough
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule
